//--- rtl/bcr_pkg.sv
// constants and types for the board control register bank
package bcr_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [4:0] BCR_BOARD = 5'h00;
    localparam logic [4:0] BCR_DEVCTL = 5'h01;
    localparam logic [4:0] BCR_CFG = 5'h02;
    localparam logic [4:0] BCR_FWID = 5'h03;
    localparam logic [4:0] BCR_MODE = 5'h04;
    localparam logic [4:0] BCR_LERR_LO = 5'h05;
    localparam logic [4:0] BCR_LERR_HI = 5'h06;
    localparam logic [4:0] BCR_ACC_ADDR = 5'h07;
    localparam logic [4:0] BCR_ACC_DATA = 5'h08;
    localparam logic [4:0] BCR_TEST_A = 5'h09;
    localparam logic [4:0] BCR_TEST_B = 5'h0a;
    localparam logic [4:0] BCR_MON_SEL = 5'h0b;
    localparam logic [4:0] BCR_MON_LO = 5'h0c;
    localparam logic [4:0] BCR_MON_HI = 5'h0d;
    localparam logic [4:0] BCR_MONH_LO = 5'h0e;
    localparam logic [4:0] BCR_MONH_HI = 5'h0f;
    localparam logic [4:0] BCR_BOARD_B = 5'h10;
    localparam logic [4:0] BCR_DATE_DAY = 5'h1c;
    localparam logic [4:0] BCR_DATE_MON = 5'h1d;
    localparam logic [4:0] BCR_DATE_YR = 5'h1e;
    localparam logic [4:0] BCR_SERIAL = 5'h1f;
    // plain read/write storage locations, with their writable bits
    localparam int BCR_NPLAIN = 10;
    localparam logic [4:0] BCR_PLAIN_OFS [BCR_NPLAIN] = '{
        5'h09, 5'h0a, 5'h0b, 5'h11, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1a, 5'h1b};
    localparam logic [7:0] BCR_PLAIN_MASK [BCR_NPLAIN] = '{
        8'h3f, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int BCR_BRD_TYPE_LSB = 4;
    localparam int BCR_BRD_HIST = 3;
    localparam int BCR_BRD_ERR = 2;
    localparam int BCR_BRD_RESET = 1;
    localparam int BCR_BRD_READY = 0;
    localparam int BCR_DEV_DONE = 7;
    localparam int BCR_DEV_ERASE = 6;
    localparam int BCR_DEV_INIT = 5;
    localparam int BCR_DEV_REGF = 4;
    localparam int BCR_MODE_PLL = 4;
    localparam int BCR_MODE_ERASE_EN = 3;
    localparam int BCR_MODE_ACC_EN = 2;
    localparam int BCR_MODE_LED = 1;
    localparam int BCR_MODE_LATCH = 0;
    localparam int BCR_B_CLR_HIST = 0;
    localparam logic [7:0] BCR_MODE_RST = 8'h12;
    localparam logic [3:0] BCR_DEV_ZERO = 4'h0;
    // broadcast codes in address bits 7..5
    localparam logic [2:0] BCR_BC_NONE = 3'h0;
    localparam logic [2:0] BCR_BC_SUBSYS = 3'h1;
    localparam logic [2:0] BCR_BC_POS = 3'h2;
    localparam logic [2:0] BCR_BC_ALL = 3'h4;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic {BCR_BUS_IDLE, BCR_BUS_ACK} bcr_bus_e;
    typedef struct packed {
        logic rd;
        logic [4:0] addr;
    } bcr_req_s;
endpackage : bcr_pkg

//--- rtl/bcr_board_ctrl.sv
// board control register bank behind the backplane address/data bus
`timescale 1ns/1ns
module bcr_board_ctrl
    import bcr_pkg::*;
#(
    parameter logic [3:0] BOARD_TYPE = 4'h5,   // arbitrary value
    parameter logic [7:0] DATE_DAY = 8'h01,
    parameter logic [7:0] DATE_MONTH = 8'h01,
    parameter logic [7:0] DATE_YEAR = 8'h00,
    parameter logic [7:0] SERIAL = 8'h00       // arbitrary value
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [4:0] slot_id_i,
    input wire logic address_valid_i,
    input wire logic write_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_n_o,
    output logic transfer_acknowledge_n_o,
    output logic transfer_acknowledge_n_oe_n_o,
    input wire logic clk_err_i,
    input wire logic [15:0] dev_done_i,
    input wire logic [15:0] link_err_i,
    input wire logic [15:0] mon_status_i,
    input wire logic [15:0] mon_hist_i,
    input wire logic [7:0] acc_rdata_i,
    output logic board_reset_o,
    output logic erase_o,
    output logic [3:0] dev_sel_o,
    output logic [7:0] cfg_byte_o,
    output logic cfg_strobe_o,
    output logic [7:0] acc_addr_o,
    output logic acc_addr_wr_o,
    output logic [7:0] acc_data_o,
    output logic acc_data_wr_o,
    output logic tx_pll_en_o,
    output logic led_show_o,
    output logic [5:0] test_en_a_o,
    output logic [5:0] test_en_b_o,
    output logic [7:0] mon_sel_o
);
    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic hit;
    logic take;
    logic wr;
    logic [4:0] ra;
    logic ready;
    logic erase_ok;
    logic access_ok;
    bcr_bus_e state_reg;
    bcr_req_s req_reg;
    logic [7:0] mode_reg;
    logic [3:0] dev_sel_reg;
    logic erase_reg;
    logic hist_reg;
    logic [7:1] board_b_reg;
    logic [15:0] lerr_reg;
    logic [15:0] lerr_view;
    logic [7:0] fw_id_reg [16];
    logic [7:0] plain_reg [BCR_NPLAIN];
    logic [7:0] rdata;

    always_comb begin
        unique case (addr_i[7:5])
            BCR_BC_NONE: hit = addr_i[12:8] == slot_id_i;
            BCR_BC_SUBSYS: hit = write_i && addr_i[12:10] == slot_id_i[4:2];
            BCR_BC_POS: hit = write_i && addr_i[9:8] == slot_id_i[1:0];
            BCR_BC_ALL: hit = write_i;
            default: hit = 1'b0;
        endcase
    end

    assign ra = addr_i[4:0];
    assign take = ce_i && address_valid_i && hit;
    assign wr = take && write_i;
    assign ready = &dev_done_i;
    assign erase_ok = !ready || mode_reg[BCR_MODE_ERASE_EN];
    assign access_ok = ready && mode_reg[BCR_MODE_ACC_EN];

    function automatic logic wr_at(input logic [4:0] a);
        wr_at = wr && ra == a;
    endfunction : wr_at

    // ------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= BCR_BUS_IDLE;
            req_reg <= '0;
            data_o <= 8'h00;
        end else if (ce_i) begin
            state_reg <= take ? BCR_BUS_ACK : BCR_BUS_IDLE;
            if (take) begin
                req_reg <= '{rd: !write_i, addr: ra};
                data_o <= rdata;
            end
        end
    end

    // the acknowledge is open drain: only ever pulled low
    assign transfer_acknowledge_n_o = 1'b0;
    assign transfer_acknowledge_n_oe_n_o = state_reg != BCR_BUS_ACK;
    assign data_oe_n_o = !(state_reg == BCR_BUS_ACK && req_reg.rd);

    // ------------------------------------------------------------
    // board status and control
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            board_reset_o <= 1'b0;
            board_b_reg <= '0;
        end else if (ce_i) begin
            if (wr_at(BCR_BOARD)) begin
                board_reset_o <= data_i[BCR_BRD_RESET];
            end
            if (wr_at(BCR_BOARD_B)) begin
                board_b_reg <= data_i[7:1];
            end
        end
    end

    // only the power-on reset and the clear bit of BCR_BOARD_B clear this flag, never the board reset bit
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hist_reg <= 1'b0;
        end else if (ce_i) begin
            if (clk_err_i) begin
                hist_reg <= 1'b1;
            end else if (wr_at(BCR_BOARD_B) && data_i[BCR_B_CLR_HIST]) begin
                hist_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // operation_mode_enables
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_reg <= BCR_MODE_RST;
        end else if (ce_i && wr_at(BCR_MODE)) begin
            mode_reg <= {3'h0, data_i[4:0]};
        end
    end

    assign tx_pll_en_o = mode_reg[BCR_MODE_PLL];

    // ------------------------------------------------------------
    // device select, erase and configuration
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dev_sel_reg <= BCR_DEV_ZERO;
            erase_reg <= 1'b0;
        end else if (ce_i && wr_at(BCR_DEVCTL)) begin
            dev_sel_reg <= data_i[3:0];
            if (erase_ok) begin
                erase_reg <= data_i[BCR_DEV_ERASE];
            end
        end
    end

    // erase holds while the bit is one and device 0 is selected; clearing it releases the devices
    assign erase_o = erase_reg && dev_sel_reg == BCR_DEV_ZERO;
    assign dev_sel_o = dev_sel_reg;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_byte_o <= 8'h00;
            cfg_strobe_o <= 1'b0;
        end else if (ce_i) begin
            cfg_strobe_o <= wr_at(BCR_CFG) && erase_ok;
            if (wr_at(BCR_CFG) && erase_ok) begin
                cfg_byte_o <= data_i;
            end
        end
    end

    // ------------------------------------------------------------
    // per-device firmware tags
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < 16; g++) begin : g_fwid
            always_ff @(posedge core_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    fw_id_reg[g] <= 8'h00;
                end else if (ce_i) begin
                    if (erase_o) begin
                        fw_id_reg[g] <= 8'h00;
                    end else if (wr_at(BCR_FWID) && dev_sel_reg == 4'(g)
                                 && !dev_done_i[g]) begin
                        fw_id_reg[g] <= data_i;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // device access pointer and data
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_addr_o <= 8'h00;
            acc_data_o <= 8'h00;
            acc_addr_wr_o <= 1'b0;
            acc_data_wr_o <= 1'b0;
        end else if (ce_i) begin
            acc_addr_wr_o <= wr_at(BCR_ACC_ADDR) && access_ok;
            acc_data_wr_o <= wr_at(BCR_ACC_DATA) && access_ok;
            if (wr_at(BCR_ACC_ADDR) && access_ok) begin
                acc_addr_o <= data_i;
            end
            if (wr_at(BCR_ACC_DATA) && access_ok) begin
                acc_data_o <= data_i;
            end
        end
    end

    // ------------------------------------------------------------
    // input link errors
    // ------------------------------------------------------------
    // a latched error clears when its register is read; a new error wins
    generate
        for (genvar g = 0; g < 16; g++) begin : g_lerr
            always_ff @(posedge core_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    lerr_reg[g] <= 1'b0;
                end else if (ce_i) begin
                    if (!mode_reg[BCR_MODE_LATCH]) begin
                        lerr_reg[g] <= 1'b0;
                    end else if (link_err_i[g]) begin
                        lerr_reg[g] <= 1'b1;
                    end else if (take && !write_i
                                 && ra == (g < 8 ? BCR_LERR_LO : BCR_LERR_HI)) begin
                        lerr_reg[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign lerr_view = mode_reg[BCR_MODE_LATCH] ? lerr_reg : link_err_i;

    // ------------------------------------------------------------
    // plain storage and monitor selection
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < BCR_NPLAIN; g++) begin : g_plain
            always_ff @(posedge core_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    plain_reg[g] <= 8'h00;
                end else if (ce_i && wr_at(BCR_PLAIN_OFS[g])) begin
                    plain_reg[g] <= data_i & BCR_PLAIN_MASK[g];
                end
            end
        end
    endgenerate

    assign test_en_a_o = plain_reg[0][5:0];
    assign test_en_b_o = plain_reg[1][5:0];
    assign mon_sel_o = plain_reg[2];

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            led_show_o <= 1'b0;
        end else if (ce_i) begin
            led_show_o <= mode_reg[BCR_MODE_LED] && wr_at(BCR_MON_SEL)
                          && data_i != plain_reg[2];
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // unimplemented locations read zero rather than floating
    always_comb begin
        rdata = 8'h00;
        unique case (ra)
            BCR_BOARD: rdata = {BOARD_TYPE, hist_reg, clk_err_i,
                                board_reset_o, ready};
            BCR_DEVCTL: rdata = {dev_done_i[dev_sel_reg], erase_reg,
                                 1'b1, 1'b0, dev_sel_reg};
            BCR_CFG: rdata = cfg_byte_o;
            BCR_FWID: rdata = fw_id_reg[dev_sel_reg];
            BCR_MODE: rdata = mode_reg;
            BCR_LERR_LO: rdata = lerr_view[7:0];
            BCR_LERR_HI: rdata = lerr_view[15:8];
            BCR_ACC_ADDR: rdata = acc_addr_o;
            BCR_ACC_DATA: rdata = access_ok ? acc_rdata_i : 8'h00;
            BCR_MON_LO: rdata = mon_status_i[7:0];
            BCR_MON_HI: rdata = mon_status_i[15:8];
            BCR_MONH_LO: rdata = mon_hist_i[7:0];
            BCR_MONH_HI: rdata = mon_hist_i[15:8];
            BCR_BOARD_B: rdata = {board_b_reg, 1'b0};
            BCR_DATE_DAY: rdata = DATE_DAY;
            BCR_DATE_MON: rdata = DATE_MONTH;
            BCR_DATE_YR: rdata = DATE_YEAR;
            BCR_SERIAL: rdata = SERIAL;
            default: begin
                for (int i = 0; i < BCR_NPLAIN; i++) begin
                    if (ra == BCR_PLAIN_OFS[i]) begin
                        rdata = plain_reg[i];
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_ack_follows_take: assert property (take |=> !transfer_acknowledge_n_oe_n_o)
        else $error("acknowledge missing after accepted address");
    a_ack_has_cause: assert property (($past(ce_i) && !transfer_acknowledge_n_oe_n_o)
        |-> $past(take))
        else $error("acknowledge without accepted address");
    a_type_code: assert property ((take && !write_i && ra == BCR_BOARD)
        |=> data_o[7:4] == BOARD_TYPE && !data_oe_n_o)
        else $error("board type code wrong");
    a_fixed_dev_bits: assert property ((take && !write_i && ra == BCR_DEVCTL)
        |=> data_o[5:4] == 2'b10)
        else $error("device register fixed bits wrong");
    a_hist_sticky: assert property ((ce_i && clk_err_i) |=> hist_reg)
        else $error("error history not latched");
    a_cfg_blocked: assert property ((wr_at(BCR_CFG) && !erase_ok)
        |=> !cfg_strobe_o)
        else $error("configuration byte passed while locked");
    a_erase_locked: assert property ((wr_at(BCR_DEVCTL) && !erase_ok)
        |=> $stable(erase_reg))
        else $error("erase bit changed while locked");
    a_access_gate: assert property ((wr_at(BCR_ACC_ADDR) && !access_ok)
        |=> $stable(acc_addr_o) && !acc_addr_wr_o)
        else $error("access pointer written while disabled");
    a_fwid_lock: assert property ((wr_at(BCR_FWID) && dev_done_i[dev_sel_reg]
        && !erase_o) |=> $stable(fw_id_reg[dev_sel_reg]))
        else $error("firmware tag changed after done");
    a_erase_wipes: assert property ((ce_i && erase_o) |=> fw_id_reg[0] == 8'h00
        && fw_id_reg[15] == 8'h00)
        else $error("firmware tags kept through erase");
    a_mode_default: assert property ($rose(rst_n_i) |-> mode_reg == BCR_MODE_RST)
        else $error("mode defaults not loaded");

    c_read_ack: cover property (take && !write_i ##1 !data_oe_n_o);
    c_cfg_byte: cover property (cfg_strobe_o ##1 !cfg_strobe_o);
    c_erase: cover property (erase_o ##1 !erase_o);
    c_broadcast: cover property (wr && addr_i[7:5] == BCR_BC_ALL);
endmodule : bcr_board_ctrl

//--- verification/bcr_ctrl_model.sv
// subrack controller model driving the backplane register bus
`timescale 1ns/1ns
module bcr_ctrl_model (
    input wire logic core_clk_i,
    output logic address_valid_o,
    output logic write_o,
    output logic [15:0] addr_o,
    output logic [7:0] data_o,
    input wire logic [7:0] rdata_i,
    input wire logic rdata_oe_n_i,
    input wire logic ack_oe_n_i
);
    // released lines sit at the backplane pull-up level, strobe held idle
    initial begin
        address_valid_o = 1'b0;
        write_o = 1'b1;
        addr_o = 16'hffff;
        data_o = 8'hff;
    end
    // one byte per transfer, answer sampled mid ack cycle; the reset bit is
    // never set by this model while devices are configuring
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ack);
        @(negedge core_clk_i);
        address_valid_o = 1'b1;
        write_o = wr;
        addr_o = a;
        data_o = wr ? d : 8'hff;
        @(negedge core_clk_i);
        ack = (ack_oe_n_i === 1'b0);
        q = (rdata_oe_n_i === 1'b0) ? rdata_i : 8'hxx;
        address_valid_o = 1'b0;
        write_o = 1'b1;
        addr_o = 16'hffff;
        data_o = 8'hff;
    endtask : xfer
endmodule : bcr_ctrl_model

//--- verification/tb_board_control_register_bank.sv
// self-checking bench for the board control register bank
`timescale 1ns/1ns
module tb_board_control_register_bank;
    import bcr_pkg::*;
    localparam logic [4:0] SLOT = 5'h03;
    localparam logic [3:0] BTYPE = 4'h5; // arbitrary value
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic av, wr_en, rd_oe_n, ack_oe_n, clk_err, brd_rst, erase, pll_en, led_show, cfg_strobe;
    logic [15:0] addr, dev_done, link_err;
    logic [7:0] wdata, rdata, acc_rdata, cfg_byte, acc_addr, mon_sel;
    logic [3:0] dev_sel;
    int n_errors = 0;
    int compares = 0;
    always #20 core_clk_i = ~core_clk_i;
    bcr_ctrl_model i_ctl (.core_clk_i(core_clk_i), .address_valid_o(av), .write_o(wr_en),
        .addr_o(addr), .data_o(wdata), .rdata_i(rdata), .rdata_oe_n_i(rd_oe_n),
        .ack_oe_n_i(ack_oe_n));
    bcr_board_ctrl #(.BOARD_TYPE(BTYPE), .DATE_DAY(8'h17)) i_dut (.core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i), .ce_i(1'b1), .slot_id_i(SLOT), .address_valid_i(av),
        .write_i(wr_en), .addr_i(addr), .data_i(wdata), .data_o(rdata),
        .data_oe_n_o(rd_oe_n), .transfer_acknowledge_n_o(),
        .transfer_acknowledge_n_oe_n_o(ack_oe_n), .clk_err_i(clk_err),
        .dev_done_i(dev_done), .link_err_i(link_err), .mon_status_i(16'h0000),
        .mon_hist_i(16'h0000), .acc_rdata_i(acc_rdata), .board_reset_o(brd_rst),
        .erase_o(erase), .dev_sel_o(dev_sel), .cfg_byte_o(cfg_byte), .cfg_strobe_o(cfg_strobe),
        .acc_addr_o(acc_addr), .acc_addr_wr_o(), .acc_data_o(), .acc_data_wr_o(),
        .tx_pll_en_o(pll_en), .led_show_o(led_show), .test_en_a_o(), .test_en_b_o(),
        .mon_sel_o(mon_sel));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        if (n_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [4:0] r, input logic [7:0] exp);
        logic [7:0] q;
        logic a;
        i_ctl.xfer(1'b0, {3'h0, SLOT, BCR_BC_NONE, r}, 8'h00, q, a);
        chk({7'h00, a}, 8'h01);
        chk(q, exp);
    endtask : rd
    task automatic wr(input logic [4:0] r, input logic [7:0] d, input logic [2:0] bc);
        logic [7:0] q;
        logic a;
        i_ctl.xfer(1'b1, {3'h0, SLOT, bc, r}, d, q, a);
        chk({7'h00, a}, 8'h01);
    endtask : wr
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] q;
        logic a;
        clk_err = 1'b0;
        link_err = 16'h0000;
        dev_done = 16'h0000;
        acc_rdata = 8'h00;
        repeat (10) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        rd(BCR_MODE, BCR_MODE_RST);
        chk({7'h00, pll_en}, 8'h01);
        rd(BCR_BOARD, {BTYPE, 4'h0});
        rd(BCR_DEVCTL, 8'h20);
        // a new monitor selection pulses the led display, a repeat does not
        wr(BCR_MON_SEL, 8'h0e, BCR_BC_NONE);
        chk({7'h00, led_show}, 8'h01);
        chk(mon_sel, 8'h0e);
        wr(BCR_MON_SEL, 8'h0e, BCR_BC_NONE);
        chk({7'h00, led_show}, 8'h00);
        wr(BCR_DATE_DAY, 8'hff, BCR_BC_NONE);
        rd(BCR_DATE_DAY, 8'h17);
        rd(5'h12, 8'h00);
        wr(BCR_TEST_A, 8'hff, BCR_BC_NONE);
        rd(BCR_TEST_A, 8'h3f);
        wr(5'h1b, 8'h9c, BCR_BC_ALL);
        rd(5'h1b, 8'h9c);
        // other slot, and a broadcast read, must stay unanswered
        i_ctl.xfer(1'b0, {3'h0, SLOT ^ 5'h01, BCR_BC_NONE, BCR_MODE}, 8'h00, q, a);
        chk({7'h00, a}, 8'h00);
        i_ctl.xfer(1'b0, {3'h0, SLOT, BCR_BC_ALL, BCR_MODE}, 8'h00, q, a);
        chk({7'h00, a}, 8'h00);
        wr(BCR_DEVCTL, 8'h03, BCR_BC_NONE);
        chk({4'h0, dev_sel}, 8'h03);
        wr(BCR_CFG, 8'ha5, BCR_BC_NONE);
        chk(cfg_byte, 8'ha5);
        chk({7'h00, cfg_strobe}, 8'h01);
        wr(BCR_FWID, 8'h3c, BCR_BC_NONE);
        dev_done = 16'h0008;
        wr(BCR_FWID, 8'h77, BCR_BC_NONE);
        rd(BCR_FWID, 8'h3c);
        rd(BCR_DEVCTL, 8'ha3);
        dev_done = 16'hffff;
        rd(BCR_BOARD, {BTYPE, 4'h1});
        wr(BCR_CFG, 8'h5a, BCR_BC_NONE);
        chk(cfg_byte, 8'ha5);
        chk({7'h00, cfg_strobe}, 8'h00);
        wr(BCR_DEVCTL, 8'h40, BCR_BC_NONE);
        chk({7'h00, erase}, 8'h00);
        wr(BCR_ACC_ADDR, 8'h11, BCR_BC_NONE);
        chk(acc_addr, 8'h00);
        wr(BCR_MODE, 8'h1c, BCR_BC_NONE);
        rd(BCR_MODE, 8'h1c);
        wr(BCR_ACC_ADDR, 8'h11, BCR_BC_NONE);
        chk(acc_addr, 8'h11);
        acc_rdata = 8'h6b;
        rd(BCR_ACC_DATA, 8'h6b);
        // erase in two steps with device 0 selected, now unlocked
        wr(BCR_DEVCTL, 8'h40, BCR_BC_NONE);
        chk({7'h00, erase}, 8'h01);
        wr(BCR_DEVCTL, 8'h03, BCR_BC_NONE);
        chk({7'h00, erase}, 8'h00);
        rd(BCR_FWID, 8'h00);
        clk_err = 1'b1;
        rd(BCR_BOARD, {BTYPE, 4'hd});
        clk_err = 1'b0;
        wr(BCR_BOARD, 8'h02, BCR_BC_NONE);
        chk({7'h00, brd_rst}, 8'h01);
        rd(BCR_BOARD, {BTYPE, 4'hb});
        wr(BCR_BOARD, 8'h00, BCR_BC_NONE);
        wr(BCR_BOARD_B, 8'h01, BCR_BC_NONE);
        rd(BCR_BOARD, {BTYPE, 4'h1});
        // a one-cycle link error stays latched until its register is read
        wr(BCR_MODE, 8'h01, BCR_BC_NONE);
        link_err = 16'h0201;
        @(negedge core_clk_i);
        link_err = 16'h0000;
        rd(BCR_LERR_LO, 8'h01);
        rd(BCR_LERR_HI, 8'h02);
        rd(BCR_LERR_LO, 8'h00);
        stop_test();
    end
    // the sequence needs well under 200 transfers of two cycles each
    initial begin
        #(40 * 5000);
        n_errors++;
        stop_test();
    end
endmodule : tb_board_control_register_bank
